// File: logic/fdc_top.v
// Fan drive configuration, automatic duty, remote 1 ramp and speed sync
// Assumes byte register access from the management bus slave and
// temperatures in whole degrees from the measurement logic
`timescale 1ns/1ps
`default_nettype none
`include "fdc_defs.vh"

module fdc_top #(
    parameter [31:0] SLOT_CYC_FAST = `FDC_SLOT_CYC_FAST,
    parameter [31:0] SLOT_CYC_SLOW = `FDC_SLOT_CYC_SLOW,
    parameter [13:0] FAST_PRESCALE = `FDC_PRE_FAST
) (
    input  wire       i_clk,
    input  wire       i_reset_n,
    input  wire [7:0] i_reg_addr,
    input  wire       i_reg_wr,
    input  wire [7:0] i_reg_wdata,
    output wire [7:0] o_reg_rdata,
    input  wire       i_config_lock,
    input  wire       i_slow_ramp,
    input  wire [7:0] i_temp_remote1,
    input  wire [7:0] i_temp_local,
    input  wire [7:0] i_temp_remote2,
    input  wire [7:0] i_start_temp_remote1,
    input  wire [7:0] i_start_temp_local,
    input  wire [7:0] i_start_temp_remote2,
    input  wire [3:0] i_hyst_remote1,
    input  wire [3:0] i_hyst_local,
    input  wire [3:0] i_hyst_remote2,
    input  wire [2:0] i_channel_behaviour_1,
    input  wire [2:0] i_channel_behaviour_2,
    input  wire [2:0] i_channel_behaviour_3,
    input  wire [7:0] i_min_duty_1,
    input  wire [7:0] i_min_duty_2,
    input  wire [7:0] i_min_duty_3,
    input  wire [7:0] i_manual_duty_1,
    input  wire [7:0] i_manual_duty_2,
    input  wire [7:0] i_manual_duty_3,
    input  wire [2:0] i_pulse_stretch,
    output wire       o_fan_drive_out_1,
    output wire       o_fan_drive_out_2,
    output wire       o_fan_drive_out_3,
    output wire [7:0] o_duty_1,
    output wire [7:0] o_duty_2,
    output wire [7:0] o_duty_3,
    output wire       o_speed_window_2,
    output wire       o_speed_window_3,
    output wire       o_speed_window_4
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    reg rst_meta_r;
    reg rst_n_r;

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [23:0] slope_rate_r;
    reg [7:0]  acoustic_r;
    reg [7:0]  rdata_r;

    always @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            slope_rate_r <= {3{`FDC_SLOPE_RATE_RST}};
            acoustic_r   <= `FDC_ACOUSTIC_RST;
        end else if (i_reg_wr && !i_config_lock) begin
            case (i_reg_addr)
                `FDC_REG_REMOTE1_SLOPE_RATE: slope_rate_r[7:0]   <= i_reg_wdata;
                `FDC_REG_LOCAL_SLOPE_RATE:   slope_rate_r[15:8]  <= i_reg_wdata;
                `FDC_REG_REMOTE2_SLOPE_RATE: slope_rate_r[23:16] <= i_reg_wdata;
                `FDC_REG_ACOUSTIC_RAMP_ONE:  acoustic_r          <= i_reg_wdata;
                default:                     acoustic_r          <= acoustic_r;
            endcase
        end
    end

    always @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_r <= 8'h00;
        end else begin
            case (i_reg_addr)
                `FDC_REG_REMOTE1_SLOPE_RATE: rdata_r <= slope_rate_r[7:0];
                `FDC_REG_LOCAL_SLOPE_RATE:   rdata_r <= slope_rate_r[15:8];
                `FDC_REG_REMOTE2_SLOPE_RATE: rdata_r <= slope_rate_r[23:16];
                `FDC_REG_ACOUSTIC_RAMP_ONE:  rdata_r <= acoustic_r;
                default:                     rdata_r <= 8'h00;
            endcase
        end
    end

    assign o_reg_rdata = rdata_r;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // Gain of 4096 / span in degrees
    function [11:0] span_gain;
        input [3:0] code;
        begin
            case (code)
                4'h0:    span_gain = 12'd2048;
                4'h1:    span_gain = 12'd1638;
                4'h2:    span_gain = 12'd1229;
                4'h3:    span_gain = 12'd1024;
                4'h4:    span_gain = 12'd819;
                4'h5:    span_gain = 12'd614;
                4'h6:    span_gain = 12'd512;
                4'h7:    span_gain = 12'd410;
                4'h8:    span_gain = 12'd307;
                4'h9:    span_gain = 12'd256;
                4'ha:    span_gain = 12'd205;
                4'hb:    span_gain = 12'd154;
                4'hc:    span_gain = 12'd128;
                4'hd:    span_gain = 12'd102;
                4'he:    span_gain = 12'd77;
                default: span_gain = 12'd51;
            endcase
        end
    endfunction

    function [7:0] ramp_increment;
        input [2:0] code;
        begin
            case (code)
                3'h0:    ramp_increment = 8'd1;
                3'h1:    ramp_increment = 8'd2;
                3'h2:    ramp_increment = 8'd3;
                3'h3:    ramp_increment = 8'd4;
                3'h4:    ramp_increment = 8'd8;
                3'h5:    ramp_increment = 8'd12;
                3'h6:    ramp_increment = 8'd24;
                default: ramp_increment = 8'd48;
            endcase
        end
    endfunction

    // Automatic duty for one sensor feeding one channel
    function [7:0] auto_duty;
        input [7:0] temp;
        input [7:0] start;
        input [3:0] hyst;
        input [3:0] span;
        input [7:0] mind;
        input       hold;
        reg   [27:0] prod;
        reg   [27:0] room;
        begin
            prod = 28'h0;
            room = {20'h00000, 8'hff - mind};
            if ({1'b0, temp} + {5'h00, hyst} < {1'b0, start}) begin
                auto_duty = hold ? mind : 8'h00;
            end else if (temp <= start) begin
                auto_duty = mind;
            end else begin
                prod = room * {20'h00000, temp - start} * {16'h0000, span_gain(span)};
                if (prod[27:12] >= room[15:0]) begin
                    auto_duty = 8'hff;
                end else begin
                    auto_duty = mind + prod[19:12];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Ramp time slot
    // ------------------------------------------------------------
    reg  [31:0] slot_cnt_r;
    reg         slot_tick_r;
    wire [31:0] slot_lim = i_slow_ramp ? SLOT_CYC_SLOW : SLOT_CYC_FAST;

    always @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            slot_cnt_r  <= 32'h00000000;
            slot_tick_r <= 1'b0;
        end else if (slot_cnt_r >= slot_lim - 32'h00000001) begin
            slot_cnt_r  <= 32'h00000000;
            slot_tick_r <= 1'b1;
        end else begin
            slot_cnt_r  <= slot_cnt_r + 32'h00000001;
            slot_tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Drive channels
    // ------------------------------------------------------------
    wire [23:0] temp_v  = {i_temp_remote2, i_temp_local, i_temp_remote1};
    wire [23:0] start_v = {i_start_temp_remote2, i_start_temp_local, i_start_temp_remote1};
    wire [11:0] hyst_v  = {i_hyst_remote2, i_hyst_local, i_hyst_remote1};
    wire [8:0]  bhv_v   = {i_channel_behaviour_3, i_channel_behaviour_2,
                           i_channel_behaviour_1};
    wire [23:0] min_v   = {i_min_duty_3, i_min_duty_2, i_min_duty_1};
    wire [23:0] man_v   = {i_manual_duty_3, i_manual_duty_2, i_manual_duty_1};
    wire [7:0]  ramp_inc = ramp_increment(acoustic_r[`FDC_RAMP_LSB +: 3]);
    wire [2:0]  drive_v;
    wire [23:0] duty_v;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_chan
            wire [2:0] bhv  = bhv_v[3*g +: 3];
            wire [7:0] mind = min_v[8*g +: 8];
            wire       hold = acoustic_r[`FDC_HOLD_LSB + g];
            wire [7:0] d_r1 = auto_duty(temp_v[7:0], start_v[7:0], hyst_v[3:0],
                                        slope_rate_r[`FDC_SPAN_LSB +: 4], mind, hold);
            wire [7:0] d_lo = auto_duty(temp_v[15:8], start_v[15:8], hyst_v[7:4],
                                        slope_rate_r[8 + `FDC_SPAN_LSB +: 4], mind, hold);
            wire [7:0] d_r2 = auto_duty(temp_v[23:16], start_v[23:16], hyst_v[11:8],
                                        slope_rate_r[16 + `FDC_SPAN_LSB +: 4], mind, hold);
            wire [7:0] m_lr = (d_lo > d_r2) ? d_lo : d_r2;
            wire       smooth = (bhv == `FDC_BHV_REMOTE1)
                                && acoustic_r[`FDC_SMOOTH_BIT];
            reg  [7:0] target;
            reg  [7:0] duty_r;

            always @* begin
                case (bhv)
                    `FDC_BHV_REMOTE1: target = d_r1;
                    `FDC_BHV_LOCAL:   target = d_lo;
                    `FDC_BHV_REMOTE2: target = d_r2;
                    `FDC_BHV_FULL:    target = 8'hff;
                    `FDC_BHV_MAX_LR2: target = m_lr;
                    `FDC_BHV_MAX_ALL: target = (d_r1 > m_lr) ? d_r1 : m_lr;
                    `FDC_BHV_MANUAL:  target = man_v[8*g +: 8];
                    default:          target = 8'h00;
                endcase
            end

            always @(posedge i_clk or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    duty_r <= 8'h00;
                end else if (!smooth) begin
                    duty_r <= target;
                end else if (slot_tick_r) begin
                    if (target > duty_r) begin
                        duty_r <= (target - duty_r > ramp_inc) ? duty_r + ramp_inc : target;
                    end else if (target < duty_r) begin
                        duty_r <= (duty_r - target > ramp_inc) ? duty_r - ramp_inc : target;
                    end
                end
            end

            assign duty_v[8*g +: 8] = duty_r;

            fdc_pwm_gen #(
                .FAST_PRESCALE (FAST_PRESCALE)
            ) u_pwm (
                .i_clk     (i_clk),
                .i_rst_n   (rst_n_r),
                .i_rate    (slope_rate_r[8*g + `FDC_RATE_LSB +: 3]),
                .i_fast    (slope_rate_r[8*g + `FDC_FAST_BIT]),
                .i_stretch (i_pulse_stretch[g]),
                .i_duty    (duty_r),
                .o_drive   (drive_v[g])
            );
        end
    endgenerate

    assign o_fan_drive_out_1 = drive_v[0];
    assign o_fan_drive_out_2 = drive_v[1];
    assign o_fan_drive_out_3 = drive_v[2];
    assign o_duty_1          = duty_v[7:0];
    assign o_duty_2          = duty_v[15:8];
    assign o_duty_3          = duty_v[23:16];

    // ------------------------------------------------------------
    // Speed measurement windows
    // ------------------------------------------------------------
    reg win2_r;
    reg win3_r;
    reg win4_r;

    always @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            win2_r <= 1'b1;
            win3_r <= 1'b0;
            win4_r <= 1'b0;
        end else begin
            win2_r <= acoustic_r[`FDC_SYNC_BIT] ? drive_v[2] : 1'b1;
            win3_r <= drive_v[2];
            win4_r <= drive_v[2];
        end
    end

    assign o_speed_window_2 = win2_r;
    assign o_speed_window_3 = win3_r;
    assign o_speed_window_4 = win4_r;

endmodule
`default_nettype wire

// File: logic/fdc_defs.vh
// Constants for the fan drive configuration and ramp block
// Assumes a 40 MHz clock and byte-wide register access
//
// How it works
// - Three-bit rate code picks low drive rate 11.0 to 88.2 Hz, reset 35.3 Hz.
// - Fast-drive select bit set gives high-frequency drive for 4-wire fans.
// - In high-frequency drive, pulse stretching has no effect on output.
// - Four-bit slope-span code sets span from 2 to 80 degrees.
// - Lock bit set makes rate/slope and ramp registers ignore writes.
// - Remote 1 channel steps duty gradually toward target at chosen rate.
// - Fast slot: increments 1,2,3,4,8,12,24,48; full sweep 37.5 s to 0.8 s.
// - Slow-ramp bit set lengthens slot; full sweep 52.2 s to 1.1 s.
// - Ramp smoothing acts only while smoothing enable bit is one.
// - Sync bit one ties speed inputs 2, 3 and 4 to drive output 3.
// - Sync bit zero ties only inputs 3 and 4; input 2 independent.
// - Below start minus hysteresis: zero duty, or minimum if hold bit set.
// - Behaviour code 000 selects remote 1 control and its ramp setting.
`ifndef FDC_DEFS_VH
`define FDC_DEFS_VH

// ------------------------
// Register map
// ------------------------
`define FDC_REG_REMOTE1_SLOPE_RATE 8'h5f
`define FDC_REG_LOCAL_SLOPE_RATE   8'h60
`define FDC_REG_REMOTE2_SLOPE_RATE 8'h61
`define FDC_REG_ACOUSTIC_RAMP_ONE  8'h62
`define FDC_SLOPE_RATE_RST         8'hc4
`define FDC_ACOUSTIC_RST           8'h00

// ------------------------
// Field positions
// ------------------------
`define FDC_RATE_LSB     0
`define FDC_FAST_BIT     3
`define FDC_SPAN_LSB     4
`define FDC_RAMP_LSB     0
`define FDC_SMOOTH_BIT   3
`define FDC_SYNC_BIT     4
`define FDC_HOLD_LSB     5

// ------------------------
// Behaviour codes
// ------------------------
`define FDC_BHV_REMOTE1  3'h0
`define FDC_BHV_LOCAL    3'h1
`define FDC_BHV_REMOTE2  3'h2
`define FDC_BHV_FULL     3'h3
`define FDC_BHV_OFF      3'h4
`define FDC_BHV_MAX_LR2  3'h5
`define FDC_BHV_MAX_ALL  3'h6
`define FDC_BHV_MANUAL   3'h7

// ------------------------
// Timing
// ------------------------
`define FDC_CLK_KHZ          40000
`define FDC_RAMP_FULL_MS     37500
`define FDC_RAMP_SLOW_MS     52200
`define FDC_SLOT_CYC_FAST    (`FDC_RAMP_FULL_MS * `FDC_CLK_KHZ / 255)
`define FDC_SLOT_CYC_SLOW    (`FDC_RAMP_SLOW_MS * `FDC_CLK_KHZ / 255)
// Prescale per duty step: clock / (rate * 256 steps)
`define FDC_PRE_11_0HZ       14'd14205
`define FDC_PRE_14_7HZ       14'd10629
`define FDC_PRE_22_1HZ       14'd7070
`define FDC_PRE_29_4HZ       14'd5314
`define FDC_PRE_35_3HZ       14'd4426
`define FDC_PRE_44_1HZ       14'd3543
`define FDC_PRE_58_8HZ       14'd2657
`define FDC_PRE_88_2HZ       14'd1771
`define FDC_PRE_FAST         14'd7
`define FDC_STRETCH_STEPS    8'h20

`endif

// File: logic/fdc_pwm_gen.v
// One fan drive output: prescaler, 256-step duty counter, stretch option
// Assumes an asynchronous active-low reset from the top module
`timescale 1ns/1ps
`default_nettype none
`include "fdc_defs.vh"

module fdc_pwm_gen #(
    parameter [13:0] FAST_PRESCALE = `FDC_PRE_FAST
) (
    input  wire       i_clk,
    input  wire       i_rst_n,
    input  wire [2:0] i_rate,
    input  wire       i_fast,
    input  wire       i_stretch,
    input  wire [7:0] i_duty,
    output wire       o_drive
);

    function [13:0] rate_prescale;
        input [2:0] code;
        begin
            case (code)
                3'h0:    rate_prescale = `FDC_PRE_11_0HZ;
                3'h1:    rate_prescale = `FDC_PRE_14_7HZ;
                3'h2:    rate_prescale = `FDC_PRE_22_1HZ;
                3'h3:    rate_prescale = `FDC_PRE_29_4HZ;
                3'h4:    rate_prescale = `FDC_PRE_35_3HZ;
                3'h5:    rate_prescale = `FDC_PRE_44_1HZ;
                3'h6:    rate_prescale = `FDC_PRE_58_8HZ;
                default: rate_prescale = `FDC_PRE_88_2HZ;
            endcase
        end
    endfunction

    reg  [13:0] pre_cnt_r;
    reg  [7:0]  step_r;
    reg         drive_r;
    wire [13:0] pre_lim = i_fast ? FAST_PRESCALE : rate_prescale(i_rate);
    wire        stretch = i_stretch && !i_fast && (i_duty != 8'h00)
                          && (step_r < `FDC_STRETCH_STEPS);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_cnt_r <= 14'h0000;
            step_r    <= 8'h00;
            drive_r   <= 1'b0;
        end else begin
            if (pre_cnt_r >= pre_lim - 14'h0001) begin
                pre_cnt_r <= 14'h0000;
                step_r    <= step_r + 8'h01;
            end else begin
                pre_cnt_r <= pre_cnt_r + 14'h0001;
            end
            drive_r <= (i_duty == 8'hff) || (step_r < i_duty) || stretch;
        end
    end

    assign o_drive = drive_r;

endmodule
`default_nettype wire

// File: verif/fdc_properties.sv
// Port-level assertions for the fan drive configuration block
// Bound to fdc_top from the testbench top file; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module fdc_properties (
    input wire logic       i_clk,
    input wire logic       i_reset_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic       i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       i_config_lock,
    input wire logic [7:0] i_temp_remote1,
    input wire logic [7:0] i_start_temp_remote1,
    input wire logic [3:0] i_hyst_remote1,
    input wire logic [2:0] i_channel_behaviour_1,
    input wire logic [7:0] i_min_duty_1,
    input wire logic       o_fan_drive_out_3,
    input wire logic [7:0] o_duty_1,
    input wire logic [7:0] o_duty_3,
    input wire logic       o_speed_window_2,
    input wire logic       o_speed_window_3,
    input wire logic       o_speed_window_4
);
    // ------------------------
    // Shadow registers and helpers
    // ------------------------
    logic [2:0] up_cnt_r;
    logic [7:0] rate1_r;
    logic [7:0] acou_r;
    logic [7:0] prev_duty_r;
    logic [7:0] prev_inc_r;
    logic       prev_sm_r;
    wire        up    = (up_cnt_r == 3'h5);
    wire        wr_ok = i_reg_wr && !i_config_lock;
    wire [7:0]  step_w = (o_duty_1 > prev_duty_r) ? o_duty_1 - prev_duty_r
                                                  : prev_duty_r - o_duty_1;

    function automatic [7:0] inc_of(input [2:0] c);
        inc_of = (c < 3'h4) ? {5'h0, c} + 8'h01 : (c == 3'h4) ? 8'h08 :
                 (c == 3'h5) ? 8'h0c : (c == 3'h6) ? 8'h18 : 8'h30;
    endfunction

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            up_cnt_r    <= 3'h0;
            rate1_r     <= 8'hc4;
            acou_r      <= 8'h00;
            prev_duty_r <= 8'h00;
            prev_inc_r  <= 8'h00;
            prev_sm_r   <= 1'b0;
        end else begin
            if (!up) up_cnt_r <= up_cnt_r + 3'h1;
            if (wr_ok && i_reg_addr == 8'h5f) rate1_r <= i_reg_wdata;
            if (wr_ok && i_reg_addr == 8'h62) acou_r <= i_reg_wdata;
            prev_duty_r <= o_duty_1;
            prev_inc_r  <= inc_of(acou_r[2:0]);
            prev_sm_r   <= acou_r[3] && (i_channel_behaviour_1 == 3'h0);
        end
    end

    // ------------------------
    // Assertions
    // ------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    win3_follow_a: assert property (up |-> o_speed_window_3 == $past(o_fan_drive_out_3))
        else $error("window 3 not following drive 3");
    win4_follow_a: assert property (up |-> o_speed_window_4 == $past(o_fan_drive_out_3))
        else $error("window 4 not following drive 3");
    win2_sync_a: assert property (up |-> o_speed_window_2 ==
        ($past(acou_r[4]) ? $past(o_fan_drive_out_3) : 1'b1))
        else $error("window 2 wrong for sync setting");
    rate_lock_a: assert property (up && $past(i_reg_addr) == 8'h5f |->
        o_reg_rdata == $past(rate1_r))
        else $error("rate register readback wrong");
    acou_lock_a: assert property (up && $past(i_reg_addr) == 8'h62 |->
        o_reg_rdata == $past(acou_r))
        else $error("ramp register readback wrong");
    below_start_a: assert property (up && i_channel_behaviour_1 == 3'h0 && !acou_r[3] &&
        ({1'b0, i_temp_remote1} + i_hyst_remote1 < {1'b0, i_start_temp_remote1})
        |=> o_duty_1 == $past(acou_r[5] ? i_min_duty_1 : 8'h00))
        else $error("below start duty wrong");
    ramp_step_a: assert property (up && prev_sm_r |-> step_w <= prev_inc_r)
        else $error("ramp step too large");
    full_drive_a: assert property (o_duty_3 == 8'hff [*3] |-> o_fan_drive_out_3)
        else $error("full duty drive low");
    zero_drive_a: assert property (o_duty_3 == 8'h00 [*3] |-> !o_fan_drive_out_3)
        else $error("zero duty drive high");

    cover property (prev_sm_r && step_w != 8'h00);
    cover property (i_config_lock && i_reg_wr);
    cover property (acou_r[4] && !o_speed_window_2);
endmodule
`default_nettype wire

// File: verif/fdc_fan_model.sv
// Fan load model: measures high time and period of one drive output
// Assumes the drive is sampled on the block clock
`timescale 1ns/1ps
`default_nettype none
module fdc_fan_model (
    input  wire logic        i_clk,
    input  wire logic        i_drive,
    output var  logic [15:0] o_high_cyc,
    output var  logic [15:0] o_period_cyc
);
    logic [15:0] high_r;
    logic [15:0] per_r;
    logic        last_r;

    always @(posedge i_clk) begin
        last_r <= i_drive;
        if (i_drive && !last_r) begin
            o_period_cyc <= per_r + 16'h1;
            per_r <= 16'h0;
            high_r <= 16'h1;
        end else begin
            per_r <= per_r + 16'h1;
            if (i_drive) high_r <= high_r + 16'h1;
            if (!i_drive && last_r) o_high_cyc <= high_r;
        end
    end
endmodule
`default_nettype wire

// File: verif/fdc_testbench.sv
// Self-checking bench for the fan drive configuration block
// Short slots and fast prescale keep the run brief
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {logic [7:0] a; logic [7:0] d; logic lk; logic [7:0] e;} fdc_row_t;
    logic       i_clk, i_reset_n, i_reg_wr, i_config_lock, i_slow_ramp;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [7:0] i_temp_remote1, i_temp_local, i_temp_remote2;
    logic [7:0] i_start_temp_remote1, i_start_temp_local, i_start_temp_remote2;
    logic [3:0] i_hyst_remote1, i_hyst_local, i_hyst_remote2;
    logic [2:0] i_channel_behaviour_1, i_channel_behaviour_2, i_channel_behaviour_3;
    logic [7:0] i_min_duty_1, i_min_duty_2, i_min_duty_3;
    logic [7:0] i_manual_duty_1, i_manual_duty_2, i_manual_duty_3;
    logic [2:0] i_pulse_stretch;
    logic       o_fan_drive_out_1, o_fan_drive_out_2, o_fan_drive_out_3;
    logic [7:0] o_duty_1, o_duty_2, o_duty_3;
    logic       o_speed_window_2, o_speed_window_3, o_speed_window_4;
    logic [15:0] fan_high, fan_period;
    int          n_mismatch = 0;
    int          tests_run = 0;
    logic [7:0]  inc_t[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h30};
    logic [7:0]  tmp_t[5] = '{8'd40, 8'd48, 8'd50, 8'd66, 8'd82};
    logic [7:0]  lin_t[5] = '{8'h00, 8'h40, 8'h40, 8'h9f, 8'hff};
    fdc_row_t    rows[9] = '{'{8'h5f, 8'h3b, 1'b0, 8'h3b}, '{8'h60, 8'ha5, 1'b0, 8'ha5},
        '{8'h61, 8'h5a, 1'b0, 8'h5a}, '{8'h62, 8'hff, 1'b0, 8'hff},
        '{8'h5f, 8'h00, 1'b1, 8'h3b}, '{8'h62, 8'h00, 1'b1, 8'hff},
        '{8'h62, 8'h00, 1'b0, 8'h00}, '{8'h63, 8'h77, 1'b0, 8'h00},
        '{8'h5e, 8'h11, 1'b0, 8'h00}};
    logic [7:0]  v;
    int          n;

    fdc_top #(.SLOT_CYC_FAST(32'd20), .SLOT_CYC_SLOW(32'd28), .FAST_PRESCALE(14'd2)) u_dut (.*);
    fdc_fan_model u_fan (.i_clk(i_clk), .i_drive(o_fan_drive_out_1),
                         .o_high_cyc(fan_high), .o_period_cyc(fan_period));

    always #12.5 i_clk = ~i_clk;

    // ------------------------
    // Tasks
    // ------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        i_reg_addr <= a;
        repeat (2) @(posedge i_clk);
        d = o_reg_rdata;
    endtask

    task automatic wait_change(input logic [7:0] old, output int k);
        k = 0;
        while (o_duty_1 === old && k < 200) begin
            @(posedge i_clk);
            k++;
        end
        if (k >= 200) begin
            check("duty change wait", 16'h0, 16'h1);
            print_verdict();
        end
    endtask

    task automatic defaults();
        for (int i = 0; i < 4; i++) begin
            reg_rd(8'h5f + i[7:0], v);
            check("reset value", (i < 3) ? 16'hc4 : 16'h00, v);
        end
        $display("test reset values done");
    endtask

    // ------------------------
    // Main sequence
    // ------------------------
    initial begin
        {i_clk, i_reset_n, i_reg_wr, i_config_lock, i_slow_ramp} = 5'h0;
        {i_reg_addr, i_reg_wdata, i_pulse_stretch} = 19'h0;
        {i_temp_remote1, i_temp_local, i_temp_remote2} = {8'd30, 8'd30, 8'd30};
        {i_start_temp_remote1, i_start_temp_local, i_start_temp_remote2} = {3{8'd50}};
        {i_hyst_remote1, i_hyst_local, i_hyst_remote2} = {3{4'h4}};
        {i_channel_behaviour_1, i_channel_behaviour_2, i_channel_behaviour_3} = 9'h124;
        {i_min_duty_1, i_min_duty_2, i_min_duty_3} = {3{8'h40}};
        {i_manual_duty_1, i_manual_duty_2, i_manual_duty_3} = {3{8'h00}};
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        defaults();
        foreach (rows[r]) begin
            i_config_lock <= rows[r].lk;
            reg_wr(rows[r].a, rows[r].d);
            reg_rd(rows[r].a, v);
            check("register row", rows[r].e, v);
        end
        i_config_lock <= 1'b0;
        $display("test register rows done");
        reg_wr(8'h60, 8'hc4);
        i_channel_behaviour_2 <= 3'h1;
        for (int t = 0; t < 5; t++) begin
            i_temp_local <= tmp_t[t];
            repeat (3) @(posedge i_clk);
            check("auto duty", lin_t[t], o_duty_2);
        end
        check("drive 2 full", 16'h1, o_fan_drive_out_2);
        reg_wr(8'h62, 8'h40);
        i_temp_local <= 8'd40;
        repeat (3) @(posedge i_clk);
        check("below start hold", 16'h40, o_duty_2);
        $display("test auto duty done");
        {i_channel_behaviour_1, i_temp_remote1, i_hyst_remote1} <= 15'h0;
        {i_start_temp_remote1, i_min_duty_1} <= {8'd100, 8'hff};
        for (int c = 0; c < 8; c++) begin
            i_slow_ramp <= c[0];
            reg_wr(8'h62, c[7:0]);
            repeat (2) @(posedge i_clk);
            check("unsmoothed duty", 16'h0, o_duty_1);
            reg_wr(8'h62, 8'h28 | c[7:0]);
            wait_change(8'h00, n);
            v = o_duty_1;
            check("first step", inc_t[c], v);
            wait_change(v, n);
            check("slot length", c[0] ? 16'd28 : 16'd20, n[15:0]);
            check("second step", {inc_t[c], 1'b0}, o_duty_1);
        end
        $display("test ramp done");
        i_channel_behaviour_1 <= 3'h7;
        i_manual_duty_1 <= 8'h80;
        reg_wr(8'h5f, 8'hcc);
        repeat (1600) @(posedge i_clk);
        check("fast period", 16'd512, fan_period);
        check("fast high", 16'd256, fan_high);
        i_manual_duty_1 <= 8'h08;
        i_pulse_stretch <= 3'h1;
        repeat (1600) @(posedge i_clk);
        check("stretch ignored", 16'd16, fan_high);
        $display("test drive done");
        i_channel_behaviour_3 <= 3'h7;
        reg_wr(8'h62, 8'h00);
        repeat (6) @(posedge i_clk);
        check("window 2 free", 16'h1, o_speed_window_2);
        check("window 3 idle", 16'h0, o_speed_window_3);
        reg_wr(8'h62, 8'h10);
        repeat (6) @(posedge i_clk);
        check("window 2 synced", 16'h0, o_speed_window_2);
        i_manual_duty_3 <= 8'hff;
        repeat (6) @(posedge i_clk);
        check("window 2 on", 16'h1, o_speed_window_2);
        check("window 4 on", 16'h1, o_speed_window_4);
        $display("test sync done");
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        defaults();
        print_verdict();
    end
endmodule

bind fdc_top fdc_properties u_prop (.*);
`default_nettype wire
